// >>> design/sccs_pkg.sv
package sccs_pkg;
  // ----------------------------------------
  // register map (index, byte address = 4x)
  // ----------------------------------------
  localparam logic [7:0]  CONTACT_IDX  = 8'hAC;
  localparam logic [7:0]  STATUS_IDX   = 8'hAD;
  localparam logic [7:0]  IFCTL_IDX    = 8'hB8;
  localparam logic [11:0] CONTACT_ADDR = {2'h0, CONTACT_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR  = {2'h0, STATUS_IDX, 2'h0};
  localparam logic [11:0] IFCTL_ADDR   = {2'h0, IFCTL_IDX, 2'h0};
  // contact control fields
  localparam int CC_VCC    = 0;
  localparam int CC_RST    = 1;
  localparam int CC_CLK    = 2;
  localparam int CC_IO     = 3;
  localparam int CC_C4     = 4;
  localparam int CC_C8     = 5;
  localparam int CC_CLKSEL = 7;
  // status fields
  localparam int ST_PE  = 0;
  localparam int ST_RC  = 1;
  localparam int ST_TC  = 2;
  localparam int ST_WTO = 3;
  localparam int ST_OK  = 4;
  localparam int ST_OVF = 5;
  localparam int ST_IN  = 6;
  localparam int ST_TBE = 7;
  // interface control fields
  localparam int IC_UART = 0;
  localparam int IC_VSEL = 1;
  localparam int IC_REP  = 3;
  localparam int IC_RSEL = 4;
  localparam logic [7:0] CONTACT_RESET = 8'h00;
  localparam logic [7:0] CONTACT_WMASK = 8'hBF;
  localparam logic [4:0] IFCTL_RESET   = 5'h00;
  localparam logic       TBE_RESET     = 1'b1;
  localparam logic [2:0] REP_LIMIT_3   = 3'h3;
  localparam logic [2:0] REP_LIMIT_4   = 3'h4;
  // supply windows in mV
  localparam logic [12:0] V0_MAX  = 13'h00C8;
  localparam logic [12:0] V18_LO  = 13'h0654;
  localparam logic [12:0] V18_HI  = 13'h07BC;
  localparam logic [12:0] V30_LO  = 13'h0A8C;
  localparam logic [12:0] V30_HI  = 13'h0CE4;
  localparam logic [12:0] V50_LO  = 13'h1194;
  localparam logic [12:0] V50_HI  = 13'h157C;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sccs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sccs_apb_rsp_t;

  typedef struct packed {
    logic tx_buf_loaded;
    logic buf_write;
    logic buf_read;
    logic wt_expired;
    logic wt_reload;
    logic tx_done;
    logic tx_card_nack;
    logic rx_done;
    logic rx_parity_bad;
    logic uart_io_level;
  } sccs_uart_ev_t;

  typedef struct packed {
    logic out;
    logic oe;
  } sccs_qpad_t;

  typedef struct packed {
    logic c8;
    logic c4;
    logic io;
    logic clk;
    logic rst;
  } sccs_pins_t;

  typedef enum logic [1:0] {
    CS_SOFT      = 2'b00,
    CS_PARK_ISO  = 2'b01,
    CS_ISO       = 2'b11,
    CS_PARK_SOFT = 2'b10
  } sccs_clksrc_e;

  typedef struct packed {
    sccs_clksrc_e st;
    logic         out;
  } sccs_clksw_t;

  localparam sccs_clksw_t CLKSW_RESET = '{st: CS_SOFT, out: 1'b0};

  typedef struct packed {
    logic [7:0] contact;
    logic [4:0] ifctl;
    logic       tbe;
    logic       wto;
    logic       tc;
    logic       rc;
    logic       pe;
    logic       presence;
    logic       ovf;
    logic       in_range;
    logic [2:0] tx_rep;
    logic [2:0] rx_rep;
    logic       rep_req;
    logic       io_sample;
    sccs_pins_t pins;
    logic [7:0] rd_data;
    logic       rd_err;
  } sccs_state_t;

  localparam sccs_state_t STATE_RESET = '{contact: CONTACT_RESET,
                                          ifctl: IFCTL_RESET,
                                          tbe: TBE_RESET,
                                          default: '0};
endpackage

// >>> design/sccs_qbidir_pin.sv
`timescale 1ns/1ps
module sccs_qbidir_pin
  import sccs_pkg::*;
(
  input  wire logic level_in,
  input  wire logic pad_in,
  output sccs_qpad_t pad_out,
  output logic       read_out
);
  // low is driven hard, high is released to the pull-up
  assign pad_out.out = 1'b0;
  assign pad_out.oe  = ~level_in;
  // latch at zero always reads zero, as on a port pin
  assign read_out    = level_in & pad_in;
endmodule

// >>> design/sccs_clk_switch.sv
`timescale 1ns/1ps
module sccs_clk_switch
  import sccs_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic select_iso_in,
  input  wire logic soft_level_in,
  input  wire logic iso_level_in,
  output logic      clk_out
);
  sccs_clksw_t s_q;
  sccs_clksw_t s_d;

  // ----------------------------------------
  // break-before-make source switch
  // ----------------------------------------
  // the old source is left only while low, the new one taken only
  // while low, so no shortened high phase reaches the pin
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      CS_SOFT: begin
        if (select_iso_in && !soft_level_in) s_d.st = CS_PARK_ISO;
      end
      CS_PARK_ISO: begin
        if (!iso_level_in) s_d.st = CS_ISO;
      end
      CS_ISO: begin
        if (!select_iso_in && !iso_level_in) s_d.st = CS_PARK_SOFT;
      end
      default: begin
        if (!soft_level_in) s_d.st = CS_SOFT;
      end
    endcase
    case (s_d.st)
      CS_SOFT: s_d.out = soft_level_in;
      CS_ISO:  s_d.out = iso_level_in;
      default: s_d.out = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) s_q <= CLKSW_RESET;
    else s_q <= s_d;
  end

  assign clk_out = s_q.out;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_soft_follow: assert property (
    (s_q.st == CS_SOFT && s_d.st == CS_SOFT) |=> clk_out == $past(soft_level_in))
    else $error("soft clock level not passed to clock output");
  a_parked_low: assert property (
    (s_q.st == CS_PARK_ISO || s_q.st == CS_PARK_SOFT) |-> !clk_out)
    else $error("clock output high while switching source");
  c_reach_iso: cover property (s_q.st == CS_PARK_ISO ##1 s_q.st == CS_ISO);
endmodule

// >>> design/sccs_contact_status.sv
// Functional notes
// - clock select picks soft level or ISO clock
// - source switching produces no clock glitch
// - reserved contact bit ignored on write
// - C8 contact level, quasi-bidirectional when high
// - C4 contact level, quasi-bidirectional when high
// - software I/O bit drives and reads pin
// - soft clock bit drives pin when selected
// - reset contact follows its bit
// - pins change only while supply in range or power bit off
// - power bit off deactivates all contacts
// - buffer empty set on load, cleared on write
// - presence bit tracks detector, no debounce
// - overcurrent bit tracks current limit live
// - supply-in-range bit tracks converter output
// - timeout set on expiry, cleared on reload
// - sent flag, success only with repetition on, read clears
// - received flag, buffer read clears
// - parity flag rules, status read clears
// - UART select routes I/O pin
// - three or four repetitions before error
// - voltage field sets supply target window
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module sccs_contact_status
  import sccs_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          reset_in,
  input  sccs_apb_req_t      apb_in,
  output sccs_apb_rsp_t      apb_out,
  input  sccs_uart_ev_t      ev_in,
  input  wire logic          presence_in,
  input  wire logic          overcurrent_in,
  input  wire logic [12:0]   supply_mv_in,
  input  wire logic          iso_card_clock_in,
  input  wire logic          pin_c8_in,
  input  wire logic          pin_c4_in,
  input  wire logic          pin_card_io_in,
  output sccs_qpad_t         pin_c8_out,
  output sccs_qpad_t         pin_c4_out,
  output sccs_qpad_t         pin_card_io_out,
  output logic               pin_card_clock_out,
  output logic               reset_contact_out,
  output logic               supply_power_on_out,
  output logic [1:0]         supply_voltage_select_out,
  output logic               uart_select_out,
  output logic               io_to_uart_out,
  output logic               repetition_request_out
);
  sccs_state_t s_q;
  sccs_state_t s_d;
  logic        apb_setup;
  logic        apb_access;
  logic        hit_contact;
  logic        hit_status;
  logic        hit_ifctl;
  logic        wr_en;
  logic        rd_status;
  logic [2:0]  rep_limit;
  logic        clk_sw;
  logic        c8_rd;
  logic        c4_rd;
  logic        io_rd;
  logic [7:0]  contact_rd;
  logic [7:0]  status_rd;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic set_wins(input logic flag,
                                    input logic set,
                                    input logic clr);
    return set | (flag & ~clr);
  endfunction

  function automatic logic supply_ok(input logic [1:0]  sel,
                                     input logic [12:0] mv);
    logic ok;
    ok = 1'b0;
    case (sel)
      2'b00:   ok = (mv <= V0_MAX);
      2'b01:   ok = (mv >= V18_LO) && (mv <= V18_HI);
      2'b10:   ok = (mv >= V30_LO) && (mv <= V30_HI);
      default: ok = (mv >= V50_LO) && (mv <= V50_HI);
    endcase
    return ok;
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign apb_setup   = apb_in.psel && !apb_in.penable;
  assign apb_access  = apb_in.psel && apb_in.penable;
  assign hit_contact = (apb_in.paddr == CONTACT_ADDR);
  assign hit_status  = (apb_in.paddr == STATUS_ADDR);
  assign hit_ifctl   = (apb_in.paddr == IFCTL_ADDR);
  assign wr_en       = apb_access && apb_in.pwrite;
  assign rd_status   = apb_access && !apb_in.pwrite && hit_status;

  // ----------------------------------------
  // contact pads
  // ----------------------------------------
  sccs_qbidir_pin u_pad_c8 (
    .level_in (s_q.pins.c8),
    .pad_in   (pin_c8_in),
    .pad_out  (pin_c8_out),
    .read_out (c8_rd)
  );

  sccs_qbidir_pin u_pad_c4 (
    .level_in (s_q.pins.c4),
    .pad_in   (pin_c4_in),
    .pad_out  (pin_c4_out),
    .read_out (c4_rd)
  );

  sccs_qbidir_pin u_pad_io (
    .level_in (s_q.pins.io),
    .pad_in   (pin_card_io_in),
    .pad_out  (pin_card_io_out),
    .read_out (io_rd)
  );

  sccs_clk_switch u_clk_switch (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .select_iso_in (s_q.contact[CC_CLKSEL]),
    .soft_level_in (s_q.contact[CC_CLK]),
    .iso_level_in  (iso_card_clock_in),
    .clk_out       (clk_sw)
  );

  // ----------------------------------------
  // read words
  // ----------------------------------------
  // bits 5..3 return the pad, so a released line reads the card
  assign contact_rd = {s_q.contact[CC_CLKSEL], 1'b0,
                       c8_rd, c4_rd, io_rd,
                       s_q.contact[CC_CLK], s_q.contact[CC_RST],
                       s_q.contact[CC_VCC]};
  assign status_rd  = {s_q.tbe, s_q.presence, s_q.ovf, s_q.in_range,
                       s_q.wto, s_q.tc, s_q.rc, s_q.pe};
  assign rep_limit  = s_q.ifctl[IC_RSEL] ? REP_LIMIT_4 : REP_LIMIT_3;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic tc_set;
    logic rc_set;
    logic pe_set;
    tc_set = 1'b0;
    rc_set = 1'b0;
    pe_set = 1'b0;
    s_d = s_q;
    s_d.rep_req   = 1'b0;
    s_d.presence  = presence_in;
    s_d.ovf       = overcurrent_in;
    s_d.in_range  = supply_ok(s_q.ifctl[IC_VSEL+1:IC_VSEL], supply_mv_in);
    s_d.io_sample = pin_card_io_in;
    // snapshot at setup; the access edge clears only what was shown
    if (apb_setup) begin
      s_d.rd_err = !(hit_contact || hit_status || hit_ifctl);
      if (hit_contact) s_d.rd_data = contact_rd;
      else if (hit_status) s_d.rd_data = status_rd;
      else if (hit_ifctl) s_d.rd_data = {3'h0, s_q.ifctl};
      else s_d.rd_data = 8'h00;
    end
    if (wr_en && hit_contact) begin
      s_d.contact = apb_in.pwdata[7:0] & CONTACT_WMASK;
    end else if (wr_en && hit_ifctl) begin
      s_d.ifctl = apb_in.pwdata[4:0];
    end
    // transmit attempts
    if (ev_in.tx_done) begin
      if (!s_q.ifctl[IC_REP] || !ev_in.tx_card_nack) begin
        tc_set = 1'b1;
        s_d.tx_rep = 3'h0;
      end else if (s_q.tx_rep == rep_limit) begin
        pe_set = 1'b1;
        s_d.tx_rep = 3'h0;
      end else begin
        s_d.tx_rep  = s_q.tx_rep + 3'h1;
        s_d.rep_req = 1'b1;
      end
    end
    // receptions
    if (ev_in.rx_done) begin
      if (!s_q.ifctl[IC_REP]) begin
        rc_set = 1'b1;
        pe_set = pe_set | ev_in.rx_parity_bad;
      end else if (!ev_in.rx_parity_bad) begin
        rc_set = 1'b1;
        s_d.rx_rep = 3'h0;
      end else if (s_q.rx_rep == rep_limit) begin
        rc_set = 1'b1;
        pe_set = 1'b1;
        s_d.rx_rep = 3'h0;
      end else begin
        s_d.rx_rep  = s_q.rx_rep + 3'h1;
        s_d.rep_req = 1'b1;
      end
    end
    s_d.tbe = set_wins(s_q.tbe, ev_in.tx_buf_loaded, ev_in.buf_write);
    s_d.wto = set_wins(s_q.wto, ev_in.wt_expired, ev_in.wt_reload);
    s_d.tc  = set_wins(s_q.tc, tc_set, rd_status && s_q.rd_data[ST_TC]);
    s_d.rc  = set_wins(s_q.rc, rc_set, ev_in.buf_read);
    s_d.pe  = set_wins(s_q.pe, pe_set, rd_status && s_q.rd_data[ST_PE]);
    // contacts: off forces all low, out of range freezes them
    if (!s_q.contact[CC_VCC]) begin
      s_d.pins = '0;
    end else if (s_q.in_range) begin
      s_d.pins.c8  = s_q.contact[CC_C8];
      s_d.pins.c4  = s_q.contact[CC_C4];
      s_d.pins.io  = s_q.ifctl[IC_UART] ? ev_in.uart_io_level
                                        : s_q.contact[CC_IO];
      s_d.pins.clk = clk_sw;
      s_d.pins.rst = s_q.contact[CC_RST];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) s_q <= STATE_RESET;
    else s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // no activation sequencer: firmware orders rst, clk and io itself
  assign supply_power_on_out       = s_q.contact[CC_VCC];
  assign supply_voltage_select_out = s_q.ifctl[IC_VSEL+1:IC_VSEL];
  assign uart_select_out           = s_q.ifctl[IC_UART];
  assign io_to_uart_out            = s_q.io_sample;
  assign repetition_request_out    = s_q.rep_req;
  assign pin_card_clock_out        = s_q.pins.clk;
  assign reset_contact_out         = s_q.pins.rst;
  assign apb_out.prdata            = {24'h000000, s_q.rd_data};
  assign apb_out.pready            = 1'b1;
  assign apb_out.pslverr           = apb_access && s_q.rd_err;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_power_off_low: assert property (
    !s_q.contact[CC_VCC] |=> s_q.pins == '0)
    else $error("contacts not low while power bit clear");
  a_frozen_out_range: assert property (
    (s_q.contact[CC_VCC] && !s_q.in_range)
      |=> ($stable(s_q.pins) || $past(s_d.pins) == '0))
    else $error("contact changed while supply out of range");
  a_rst_follows: assert property (
    (s_q.contact[CC_VCC] && s_q.in_range) |=>
      reset_contact_out == $past(s_q.contact[CC_RST]))
    else $error("reset contact does not follow its bit");
  a_tbe_set_wins: assert property (
    ev_in.tx_buf_loaded |=> s_q.tbe)
    else $error("buffer empty lost on load");
  a_tbe_clear_wr: assert property (
    (ev_in.buf_write && !ev_in.tx_buf_loaded) |=> !s_q.tbe)
    else $error("buffer empty not cleared by buffer write");
  a_wto_reload: assert property (
    (ev_in.wt_reload && !ev_in.wt_expired) |=> !s_q.wto)
    else $error("timeout not cleared by reload");
  a_rc_clear_read: assert property (
    (ev_in.buf_read && !ev_in.rx_done) |=> !s_q.rc)
    else $error("received flag not cleared by buffer read");
  a_tc_read_clear: assert property (
    (apb_setup && hit_status && !apb_in.pwrite && s_q.tc && !ev_in.tx_done)
      ##1 (rd_status && !ev_in.tx_done) |=> !s_q.tc)
    else $error("sent flag survives status read");
  a_pe_held_rep: assert property (
    (s_q.ifctl[IC_REP] && ev_in.rx_done && ev_in.rx_parity_bad &&
     s_q.rx_rep != rep_limit && !ev_in.tx_done && !s_q.pe)
      |=> !s_q.pe && repetition_request_out)
    else $error("parity flag raised before last repetition");
  a_pe_final_rep: assert property (
    (s_q.ifctl[IC_REP] && ev_in.rx_done && ev_in.rx_parity_bad &&
     s_q.rx_rep == rep_limit) |=> s_q.pe && s_q.rc && s_q.rx_rep == 3'h0)
    else $error("final bad repetition not flagged");
  a_read_set_wins: assert property (
    (rd_status && ev_in.tx_done && !ev_in.tx_card_nack) |=> s_q.tc)
    else $error("sent event lost during status read");

  c_power_up: cover property (
    !s_q.contact[CC_VCC] ##1 s_q.contact[CC_VCC] && s_q.in_range ##1 s_q.pins.rst);
  c_final_rep: cover property (
    s_q.ifctl[IC_REP] && ev_in.rx_done && ev_in.rx_parity_bad &&
    s_q.rx_rep == rep_limit);
  c_status_clear: cover property (rd_status && s_q.rd_data[ST_PE]);
  c_uart_io: cover property (s_q.ifctl[IC_UART] && s_q.contact[CC_VCC] && s_q.in_range);
endmodule

// >>> dv/sccs_card_model.sv
`timescale 1ns/1ps
module sccs_card_model
  import sccs_pkg::*;
(
  input  sccs_qpad_t        c8_pad_in,
  input  sccs_qpad_t        c4_pad_in,
  input  sccs_qpad_t        io_pad_in,
  input  wire logic         card_reset_in,
  input  wire logic         power_on_in,
  input  wire logic         io_hold_low_in,
  input  wire logic         inserted_in,
  input  wire logic         overload_in,
  input  wire logic [12:0]  supply_mv_in,
  output logic              c8_wire_out,
  output logic              c4_wire_out,
  output logic              io_wire_out,
  output logic              presence_out,
  output logic              overcurrent_out,
  output logic [12:0]       supply_mv_out
);
  // ----------------------------------------
  // contact lines
  // ----------------------------------------
  // released lines float to the pull-up level, never to the last value
  assign c8_wire_out = c8_pad_in.oe ? c8_pad_in.out : 1'b1;
  assign c4_wire_out = c4_pad_in.oe ? c4_pad_in.out : 1'b1;
  // card only answers once powered and out of reset
  assign io_wire_out = (io_pad_in.oe ? io_pad_in.out : 1'b1)
                       & ~(io_hold_low_in & power_on_in & card_reset_in);
  // ----------------------------------------
  // sensing
  // ----------------------------------------
  // contact bounce is left to software, so no filtering here either
  assign presence_out    = inserted_in;
  assign overcurrent_out = overload_in & power_on_in;
  assign supply_mv_out   = supply_mv_in;
endmodule

// >>> dv/tb_smart_card_contact_status_regs.sv
`timescale 1ns/1ps
module tb_smart_card_contact_status_regs;
  import sccs_pkg::*;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic          clk, rst, hold_low, inserted, overload, mon_en, seen, e;
  logic          c8_w, c4_w, io_w, pres, ovf, clk_p, rst_p, pwr_p, usel_p, i2u_p, rep_p;
  logic          clk_q, iso_q;
  logic [2:0]    iso_cnt = 3'h0;
  logic [7:0]    q;
  logic [1:0]    vsel_p;
  logic [12:0]   mv, mv_w;
  logic [12:0]   lo [4];
  logic [12:0]   hi [4];
  sccs_apb_req_t req;
  sccs_apb_rsp_t rsp;
  sccs_uart_ev_t ev;
  sccs_qpad_t    c8_p, c4_p, io_p;
  int            n_fail, n_tests, run, rise_p, rise_i, a, b;
  wire logic [7:0] pv = {2'h0, c8_p.oe, c4_p.oe, io_p.oe, clk_p, rst_p, pwr_p};

  sccs_contact_status i_dut (.core_clk_in(clk), .reset_in(rst), .apb_in(req), .apb_out(rsp),
    .ev_in(ev), .presence_in(pres), .overcurrent_in(ovf), .supply_mv_in(mv_w),
    .iso_card_clock_in(iso_cnt[2]), .pin_c8_in(c8_w), .pin_c4_in(c4_w),
    .pin_card_io_in(io_w), .pin_c8_out(c8_p), .pin_c4_out(c4_p), .pin_card_io_out(io_p),
    .pin_card_clock_out(clk_p), .reset_contact_out(rst_p), .supply_power_on_out(pwr_p),
    .supply_voltage_select_out(vsel_p), .uart_select_out(usel_p), .io_to_uart_out(i2u_p),
    .repetition_request_out(rep_p));

  sccs_card_model i_card (.c8_pad_in(c8_p), .c4_pad_in(c4_p), .io_pad_in(io_p),
    .card_reset_in(rst_p), .power_on_in(pwr_p), .io_hold_low_in(hold_low),
    .inserted_in(inserted), .overload_in(overload), .supply_mv_in(mv), .c8_wire_out(c8_w),
    .c4_wire_out(c4_w), .io_wire_out(io_w), .presence_out(pres), .overcurrent_out(ovf),
    .supply_mv_out(mv_w));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // iso clock with four-cycle halves; a shorter high on the pin is a runt
  always @(posedge clk) begin
    iso_cnt <= iso_cnt + 3'h1;
    clk_q <= clk_p;
    iso_q <= iso_cnt[2];
    run <= clk_p ? run + 1 : 0;
    if (mon_en && clk_p && !clk_q) rise_p <= rise_p + 1;
    if (mon_en && iso_cnt[2] && !iso_q) rise_i <= rise_i + 1;
    if (mon_en && !clk_p && run > 0 && run < 4) begin
      n_fail++;
      $display("BAD card clock high run expected 4 seen %0d", run);
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d,
                     input sccs_uart_ev_t ea);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    ev <= ea;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    ev <= '0;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // one idle edge: outputs settle and the next call never re-drives req in this step
    @(posedge clk);
    if (n >= 20) begin
      n_fail++;
      $display("BAD pready expected 1 seen %b", rsp.pready);
      give_verdict();
    end
  endtask

  task automatic st(input string nm, input logic [7:0] m, input logic [7:0] x);
    apb(1'b0, STATUS_ADDR, 8'h00, '0);
    chk(nm, x, q & m);
  endtask

  // event pulse lasts one cycle; the repeat request is caught the cycle after
  task automatic pulse(input sccs_uart_ev_t p);
    ev <= p;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
    seen = rep_p;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    ev = '0;
    {hold_low, inserted, overload, mon_en} = 4'h0;
    {rise_p, rise_i, run, n_fail, n_tests} = '0;
    mv = 13'h0000;
    lo = '{13'h0000, V18_LO, V30_HI, V50_LO};
    hi = '{V0_MAX + 13'h0001, V18_HI + 13'h0001, V30_LO - 13'h0001, V50_HI + 13'h0001};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CONTACT_ADDR, 8'h00, '0);
    chk("contact reset", 8'h00, q);
    st("status reset", 8'hFF, 8'h90);
    chk("pins reset", 8'h38, pv);
    apb(1'b0, 12'h004, 8'h00, '0);
    chk("unmapped error", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, q);
    done("reset and map");
    apb(1'b1, CONTACT_ADDR, 8'h3E, '0);
    cyc(3);
    chk("pins unpowered", 8'h38, pv);
    apb(1'b0, CONTACT_ADDR, 8'h00, '0);
    chk("contact unpowered", 8'h06, q);
    apb(1'b1, IFCTL_ADDR, 8'h02, '0);
    apb(1'b1, CONTACT_ADDR, 8'h3F, '0);
    cyc(3);
    chk("pins out of range", 8'h39, pv);
    st("supply low", 8'h10, 8'h00);
    mv <= V18_LO;
    cyc(4);
    chk("pins active", 8'h07, pv);
    hold_low <= 1'b1;
    apb(1'b1, CONTACT_ADDR, 8'h7F, '0);
    apb(1'b0, CONTACT_ADDR, 8'h00, '0);
    chk("io read low", 8'h37, q);
    hold_low <= 1'b0;
    cyc(2);
    apb(1'b0, CONTACT_ADDR, 8'h00, '0);
    chk("io read high", 8'h3F, q);
    apb(1'b1, CONTACT_ADDR, 8'h37, '0);
    cyc(3);
    chk("io driven low", 8'h0F, pv);
    done("contacts");
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, IFCTL_ADDR, {5'h0, 2'(v), 1'b0}, '0);
      chk("voltage select", 8'(v), {6'h0, vsel_p});
      mv <= lo[v];
      cyc(3);
      st("in range", 8'h10, 8'h10);
      mv <= hi[v];
      cyc(3);
      st("out of range", 8'h10, 8'h00);
    end
    apb(1'b1, IFCTL_ADDR, 8'h02, '0);
    mv <= V18_LO;
    cyc(3);
    done("supply windows");
    apb(1'b1, CONTACT_ADDR, 8'h33, '0);
    mon_en <= 1'b1;
    apb(1'b1, CONTACT_ADDR, 8'hB3, '0);
    cyc(20);
    a = rise_p;
    b = rise_i;
    cyc(32);
    chk("iso clock rises", 8'(rise_i - b), 8'(rise_p - a));
    apb(1'b1, CONTACT_ADDR, 8'h33, '0);
    cyc(12);
    chk("soft clock low", 8'h0B, pv);
    apb(1'b1, CONTACT_ADDR, 8'h37, '0);
    cyc(4);
    chk("soft clock high", 8'h0F, pv);
    mon_en <= 1'b0;
    done("card clock");
    apb(1'b1, IFCTL_ADDR, 8'h03, '0);
    cyc(3);
    chk("uart drives low", 8'h03, {6'h0, usel_p, io_p.oe});
    ev.uart_io_level <= 1'b1;
    hold_low <= 1'b1;
    cyc(3);
    chk("uart releases", 8'h02, {6'h0, usel_p, io_p.oe});
    chk("io to uart low", 8'h00, {7'h0, i2u_p});
    hold_low <= 1'b0;
    cyc(3);
    chk("io to uart high", 8'h01, {7'h0, i2u_p});
    ev <= '0;
    apb(1'b1, IFCTL_ADDR, 8'h02, '0);
    inserted <= 1'b1;
    overload <= 1'b1;
    cyc(2);
    st("live set", 8'h60, 8'h60);
    inserted <= 1'b0;
    overload <= 1'b0;
    cyc(2);
    st("live clear", 8'h60, 8'h00);
    done("routing and live bits");
    pulse('{buf_write: 1'b1, default: 1'b0});
    st("tbe cleared", 8'h80, 8'h00);
    pulse('{tx_buf_loaded: 1'b1, default: 1'b0});
    st("tbe set", 8'h80, 8'h80);
    pulse('{wt_expired: 1'b1, default: 1'b0});
    st("timeout set", 8'h08, 8'h08);
    pulse('{wt_reload: 1'b1, default: 1'b0});
    st("timeout reload", 8'h08, 8'h00);
    pulse('{tx_done: 1'b1, default: 1'b0});
    st("sent set", 8'h04, 8'h04);
    st("sent read clear", 8'h04, 8'h00);
    pulse('{rx_done: 1'b1, rx_parity_bad: 1'b1, default: 1'b0});
    st("rx and parity", 8'h03, 8'h03);
    st("parity read clear", 8'h03, 8'h02);
    pulse('{buf_read: 1'b1, default: 1'b0});
    st("received cleared", 8'h02, 8'h00);
    pulse('{tx_done: 1'b1, default: 1'b0});
    apb(1'b0, STATUS_ADDR, 8'h00, '{tx_done: 1'b1, default: 1'b0});
    st("event during read", 8'h04, 8'h04);
    st("sent cleared", 8'h04, 8'h00);
    done("status events");
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, IFCTL_ADDR, {3'h0, 1'(r), 1'b1, 2'b01, 1'b0}, '0);
      for (int i = 0; i < 3 + r; i++) begin
        pulse('{tx_done: 1'b1, tx_card_nack: 1'b1, default: 1'b0});
        chk("tx repeat request", 8'h01, {7'h0, seen});
      end
      pulse('{tx_done: 1'b1, tx_card_nack: 1'b1, default: 1'b0});
      chk("tx last no request", 8'h00, {7'h0, seen});
      st("tx last flags", 8'h05, 8'h01);
      for (int i = 0; i < 3 + r; i++) begin
        pulse('{rx_done: 1'b1, rx_parity_bad: 1'b1, default: 1'b0});
        chk("rx repeat request", 8'h01, {7'h0, seen});
      end
      pulse('{rx_done: 1'b1, rx_parity_bad: 1'b1, default: 1'b0});
      st("rx last flags", 8'h03, 8'h03);
      pulse('{buf_read: 1'b1, default: 1'b0});
    end
    done("repetition");
    give_verdict();
  end
endmodule
